/* File: hdl/fsq_flash_ctrl.v */
// flash controller interrupt, security and reset sequence logic
`timescale 1ns/1ns
`include "fsq_defs.vh"
module fsq_flash_ctrl (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // apb slave
  input  wire [7:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // flash array engine
  output reg         nvm_req,
  output reg  [7:0]  nvm_op,
  output reg  [17:0] nvm_addr,
  output reg  [15:0] nvm_wdata,
  output reg  [2:0]  nvm_wcount,
  output reg         nvm_abort,
  input  wire        nvm_done,
  input  wire [15:0] nvm_rdata,
  input  wire        nvm_err,
  input  wire        nvm_dfault,
  // cpu read path faults
  input  wire        rd_ecc_single,
  input  wire        rd_ecc_double,
  output reg         read_block,
  // mode and power
  input  wire        special_mode_pin,
  input  wire        stop_req,
  output reg         stop_ack,
  // security
  output reg  [7:0]  lock_register,
  output reg         debug_enable,
  // interrupts
  output reg         cmd_irq,
  output reg         err_irq,
  output reg         irq
);

  localparam ST_INIT = 3'h0;
  localparam ST_RDW  = 3'h1;
  localparam ST_IDLE = 3'h2;
  localparam ST_CMD  = 3'h3;
  localparam ST_KEY  = 3'h4;

  // ======================================================
  // state
  reg  [2:0]  state;
  reg  [2:0]  sidx;
  reg         seq_bad;
  reg         hold;
  reg         command_complete_flag;
  reg         command_complete_flag_q;
  reg         access_error;
  reg  [1:0]  controller_error_bits;
  reg         command_complete_irq_enable;
  reg         single_fault_irq_enable;
  reg         double_fault_irq_enable;
  reg         single_fault_flag;
  reg         double_fault_flag;
  reg  [2:0]  command_index;
  reg  [15:0] cmd_mem [0:7];
  reg  [15:0] key_store [0:3];
  reg  [7:0]  program_area_guard;
  reg  [7:0]  data_area_guard;
  reg  [7:0]  option_register;
  reg  [15:0] block_params;
  reg  [1:0]  kcnt;
  reg         key_ok;
  reg         key_locked;
  reg  [2:0]  irq_status;
  reg  [2:0]  irq_enable;
  reg         sm_meta;
  reg         sm_sync;
  reg  [31:0] rd_mux;
  reg         mapped;

  wire [1:0]  protection_lock_state  = lock_register[1:0];
  wire [1:0]  backdoor_access_switch = lock_register[7:6];

  // ======================================================
  // bus decode
  wire        acc     = psel & penable;
  wire        wr      = acc & pready & pwrite;
  wire        lead    = acc & ~pready & ~hold;
  wire        wr_cfg  = wr & (paddr == `FSQ_A_CFG);
  wire        wr_ecfg = wr & (paddr == `FSQ_A_ERRCFG);
  wire        wr_stat = wr & (paddr == `FSQ_A_STAT);
  wire        wr_est  = wr & (paddr == `FSQ_A_ERRSTAT);
  wire        wr_irqe = wr & (paddr == `FSQ_A_IRQEN);
  wire        wr_irqc = wr & (paddr == `FSQ_A_IRQCLR);
  // command buffer closed while the flag is clear
  wire        cmd_wr  = wr & command_complete_flag;
  wire        wr_idx  = cmd_wr & (paddr == `FSQ_A_IDX);
  wire        wr_hi   = cmd_wr & (paddr == `FSQ_A_HI);
  wire        wr_lo   = cmd_wr & (paddr == `FSQ_A_LO);
  wire        launch  = wr_stat & pwdata[`FSQ_B_COMMAND_COMPLETE_FLAG] & command_complete_flag;
  wire [7:0]  opcode  = cmd_mem[0][15:8];

  // ======================================================
  // key compare
  wire [15:0] key_in  = cmd_mem[{1'b0, kcnt} + 3'h1];
  wire        key_hit = (key_in == key_store[kcnt]) &&
                        (key_in != `FSQ_KEY_ZERO) &&
                        (key_in != `FSQ_KEY_ONES);
  wire        key_allowed = (backdoor_access_switch == `FSQ_BACKDOOR_ACCESS_SWITCH_ON) &&
                            ~key_locked && (command_index == `FSQ_KEY_IDX);

  function [17:0] seq_addr;
    input [2:0] i;
    begin
      case (i)
        3'h0:    seq_addr = `FSQ_AD_BLKPAR;
        3'h1:    seq_addr = `FSQ_AD_KEY0;
        3'h2:    seq_addr = `FSQ_AD_KEY0 + 18'h2;
        3'h3:    seq_addr = `FSQ_AD_KEY0 + 18'h4;
        3'h4:    seq_addr = `FSQ_AD_KEY0 + 18'h6;
        3'h5:    seq_addr = `FSQ_AD_GUARDS;
        default: seq_addr = `FSQ_AD_OPTSEC;
      endcase
    end
  endfunction

  // ======================================================
  // mode pin synchroniser
  always @(posedge clk) begin
    if (rst) begin
      sm_meta <= 1'b0;
      sm_sync <= 1'b0;
    end else begin
      sm_meta <= special_mode_pin;
      sm_sync <= sm_meta;
    end
  end

  // ======================================================
  // reset sequence and command engine
  always @(posedge clk) begin
    if (rst) begin
      state                 <= ST_INIT;
      sidx                  <= 3'h0;
      seq_bad               <= 1'b0;
      hold                  <= 1'b1;
      command_complete_flag <= 1'b0;
      access_error          <= 1'b0;
      controller_error_bits <= 2'h0;
      nvm_req               <= 1'b0;
      nvm_op                <= 8'h00;
      nvm_addr              <= 18'h00000;
      nvm_wdata             <= 16'h0000;
      nvm_wcount            <= 3'h0;
      read_block            <= 1'b0;
      kcnt                  <= 2'h0;
      key_ok                <= 1'b0;
      key_locked            <= 1'b0;
      debug_enable          <= 1'b0;
      lock_register         <= `FSQ_LOCK_DFLT;
      program_area_guard    <= `FSQ_GUARD_DFLT;
      data_area_guard       <= `FSQ_GUARD_DFLT;
      option_register       <= `FSQ_OPT_DFLT;
      block_params          <= `FSQ_BLK_DFLT;
    end else begin
      if (wr_stat && pwdata[`FSQ_B_ACCERR])
        access_error <= 1'b0;
      case (state)
        ST_INIT: begin
          nvm_req  <= 1'b1;
          nvm_op   <= `FSQ_OP_READ;
          nvm_addr <= seq_addr(sidx);
          state    <= ST_RDW;
        end
        ST_RDW: begin
          if (nvm_done) begin
            nvm_req <= 1'b0;
            case (sidx)
              3'h0:    block_params <= nvm_rdata;
              3'h5: begin
                program_area_guard <= nvm_rdata[15:8];
                data_area_guard    <= nvm_rdata[7:0];
              end
              3'h6: begin
                option_register <= nvm_rdata[15:8];
                lock_register   <= nvm_rdata[7:0];
              end
              default: key_store[sidx[1:0] - 2'h1] <= nvm_rdata;
            endcase
            if (nvm_dfault)
              controller_error_bits <= `FSQ_MG_BOTH;
            if (nvm_err || nvm_dfault)
              seq_bad <= 1'b1;
            // the bus stall ends once the block parameters are in
            if (sidx == `FSQ_HOLD_LAST)
              hold <= 1'b0;
            if (sidx == `FSQ_SEQ_LAST) begin
              // any error leaves the part protected and secured
              if (seq_bad || nvm_err || nvm_dfault) begin
                block_params       <= `FSQ_BLK_DFLT;
                program_area_guard <= `FSQ_GUARD_DFLT;
                data_area_guard    <= `FSQ_GUARD_DFLT;
                option_register    <= `FSQ_OPT_DFLT;
                lock_register      <= `FSQ_LOCK_DFLT;
              end
              command_complete_flag <= 1'b1;
              state                 <= ST_IDLE;
            end else begin
              sidx  <= sidx + 3'h1;
              state <= ST_INIT;
            end
          end
        end
        ST_IDLE: begin
          if (launch) begin
            controller_error_bits <= 2'h0;
            if (opcode == `FSQ_OP_KEY) begin
              if (key_allowed) begin
                command_complete_flag <= 1'b0;
                read_block            <= 1'b1;
                kcnt                  <= 2'h0;
                key_ok                <= 1'b1;
                state                 <= ST_KEY;
              end else begin
                access_error <= 1'b1;
              end
            end else begin
              command_complete_flag <= 1'b0;
              nvm_req    <= 1'b1;
              nvm_op     <= opcode;
              nvm_addr   <= {cmd_mem[0][1:0], cmd_mem[1]};
              nvm_wdata  <= cmd_mem[2];
              nvm_wcount <= command_index;
              state      <= ST_CMD;
            end
          end
        end
        ST_CMD: begin
          // program commands never touch the live lock state
          if (nvm_done) begin
            nvm_req               <= 1'b0;
            command_complete_flag <= 1'b1;
            controller_error_bits <= {nvm_err | nvm_dfault, nvm_dfault};
            if (nvm_op == `FSQ_OP_EVALL && sm_sync && !nvm_err && !nvm_dfault) begin
              lock_register[1:0] <= `FSQ_SEC_UNSEC;
              debug_enable       <= 1'b1;
            end
            state <= ST_IDLE;
          end
        end
        ST_KEY: begin
          // one key per cycle; stored keys and guards stay as loaded
          if (!key_hit)
            key_ok <= 1'b0;
          if (kcnt == 2'h3) begin
            if (key_ok && key_hit)
              lock_register[1:0] <= `FSQ_SEC_UNSEC;
            else
              key_locked <= 1'b1;
            read_block            <= 1'b0;
            command_complete_flag <= 1'b1;
            state                 <= ST_IDLE;
          end
          kcnt <= kcnt + 2'h1;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // command buffer, no reset needed for data words
  always @(posedge clk) begin
    if (wr_hi)
      cmd_mem[command_index][15:8] <= pwdata[7:0];
    if (wr_lo)
      cmd_mem[command_index][7:0] <= pwdata[7:0];
  end

  // abort only lasts the reset edge; array contents then undefined
  always @(posedge clk) begin
    nvm_abort <= rst & nvm_req;
  end

  // ======================================================
  // software control registers and fault flags
  always @(posedge clk) begin
    if (rst) begin
      command_index               <= 3'h0;
      command_complete_irq_enable <= 1'b0;
      single_fault_irq_enable     <= 1'b0;
      double_fault_irq_enable     <= 1'b0;
      single_fault_flag           <= 1'b0;
      double_fault_flag           <= 1'b0;
      irq_enable                  <= 3'h0;
      irq_status                  <= 3'h0;
      command_complete_flag_q                      <= 1'b0;
    end else begin
      if (wr_idx)
        command_index <= pwdata[2:0];
      if (wr_cfg)
        command_complete_irq_enable <= pwdata[`FSQ_B_COMMAND_COMPLETE_IRQ_ENABLE];
      if (wr_ecfg) begin
        single_fault_irq_enable <= pwdata[`FSQ_B_SINGLE_FAULT_IRQ_ENABLE];
        double_fault_irq_enable <= pwdata[`FSQ_B_DOUBLE_FAULT_IRQ_ENABLE];
      end
      if (wr_irqe)
        irq_enable <= pwdata[2:0];
      // a fault in the clearing cycle still lands
      single_fault_flag <= (single_fault_flag &
                            ~(wr_est & pwdata[`FSQ_B_SINGLE_FAULT_FLAG])) | rd_ecc_single;
      double_fault_flag <= (double_fault_flag &
                            ~(wr_est & pwdata[`FSQ_B_DOUBLE_FAULT_FLAG])) | rd_ecc_double;
      command_complete_flag_q     <= command_complete_flag;
      irq_status <= (irq_status & ~({3{wr_irqc}} & pwdata[2:0])) |
                    {rd_ecc_double, rd_ecc_single,
                     command_complete_flag & ~command_complete_flag_q};
    end
  end

  // ======================================================
  // interrupt and power outputs
  always @(posedge clk) begin
    if (rst) begin
      cmd_irq  <= 1'b0;
      err_irq  <= 1'b0;
      irq      <= 1'b0;
      stop_ack <= 1'b0;
    end else begin
      // level also serves as the wake source out of wait
      cmd_irq  <= command_complete_flag & command_complete_irq_enable;
      err_irq  <= (double_fault_flag & double_fault_irq_enable) |
                  (single_fault_flag & single_fault_irq_enable);
      irq      <= |(irq_status & irq_enable);
      stop_ack <= stop_req & command_complete_flag;
    end
  end

  // ======================================================
  // read mux
  always @* begin
    rd_mux = 32'h00000000;
    mapped = 1'b1;
    case (paddr)
      `FSQ_A_CFG:     rd_mux[`FSQ_B_COMMAND_COMPLETE_IRQ_ENABLE] = command_complete_irq_enable;
      `FSQ_A_ERRCFG:  rd_mux[1:0] = {double_fault_irq_enable, single_fault_irq_enable};
      `FSQ_A_STAT: begin
        rd_mux[`FSQ_B_COMMAND_COMPLETE_FLAG]   = command_complete_flag;
        rd_mux[`FSQ_B_ACCERR] = access_error;
        rd_mux[1:0]           = controller_error_bits;
      end
      `FSQ_A_ERRSTAT: rd_mux[1:0] = {double_fault_flag, single_fault_flag};
      `FSQ_A_IDX:     rd_mux[2:0] = command_index;
      `FSQ_A_HI:      rd_mux[7:0] = cmd_mem[command_index][15:8];
      `FSQ_A_LO:      rd_mux[7:0] = cmd_mem[command_index][7:0];
      `FSQ_A_LOCK:    rd_mux[7:0] = lock_register;
      `FSQ_A_PGUARD:  rd_mux[7:0] = program_area_guard;
      `FSQ_A_DGUARD:  rd_mux[7:0] = data_area_guard;
      `FSQ_A_OPT:     rd_mux[7:0] = option_register;
      `FSQ_A_BLKPAR:  rd_mux[15:0] = block_params;
      `FSQ_A_IRQST:   rd_mux[2:0] = irq_status;
      `FSQ_A_IRQEN:   rd_mux[2:0] = irq_enable;
      `FSQ_A_IRQCLR:  rd_mux = 32'h00000000;
      default:        mapped = 1'b0;
    endcase
  end

  // ======================================================
  // apb answer: one wait state, longer while the bus is held
  always @(posedge clk) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= lead;
      pslverr <= lead & ~mapped;
      if (lead && !pwrite)
        prdata <= rd_mux;
    end
  end

endmodule // fsq_flash_ctrl

/* File: hdl/fsq_defs.vh */
// constants for the flash interrupt, security and reset sequence block
// Function
// - command irq is high when command complete flag and its enable are set
// - error irq is high when a fault flag and its matching enable are set
// - wait mode leaves flash alone; command irq can wake the processor
// - stop is granted only once no flash command is running
// - reset loads the lock register from the security byte at 0x3FF0F
// - a newly programmed security byte acts only after the next reset
// - matching four backdoor keys with access enabled forces state to unsecure
// - keys 0x0000 and 0xFFFF never match
// - flash reads are blocked and invalid while key verify runs
// - one failed key attempt blocks key verify until next reset
// - key verify changes only the live lock state, nothing stored
// - special mode erase verify all passing unsecures and enables debug commands
// - reset sequence loads parameters, guards, option, lock; errors give safe defaults
// - double fault in reset sequence sets both controller error bits
// - complete flag stays clear in reset sequence; early part stalls the bus
// - command index and word writes are dropped until the sequence completes
// - reset aborts any running command at once
`ifndef FSQ_DEFS_VH
`define FSQ_DEFS_VH
// ======================================================
// register offsets
`define FSQ_A_CFG     8'h00
`define FSQ_A_ERRCFG  8'h04
`define FSQ_A_STAT    8'h08
`define FSQ_A_ERRSTAT 8'h0C
`define FSQ_A_IDX     8'h10
`define FSQ_A_HI      8'h14
`define FSQ_A_LO      8'h18
`define FSQ_A_LOCK    8'h1C
`define FSQ_A_PGUARD  8'h20
`define FSQ_A_DGUARD  8'h24
`define FSQ_A_OPT     8'h28
`define FSQ_A_BLKPAR  8'h2C
`define FSQ_A_IRQST   8'h30
`define FSQ_A_IRQEN   8'h34
`define FSQ_A_IRQCLR  8'h38
// ======================================================
// field positions
`define FSQ_B_COMMAND_COMPLETE_IRQ_ENABLE    0
`define FSQ_B_SINGLE_FAULT_IRQ_ENABLE   0
`define FSQ_B_DOUBLE_FAULT_IRQ_ENABLE   1
`define FSQ_B_COMMAND_COMPLETE_FLAG    7
`define FSQ_B_ACCERR  5
`define FSQ_B_SINGLE_FAULT_FLAG   0
`define FSQ_B_DOUBLE_FAULT_FLAG   1
`define FSQ_B_EV_CMD  0
`define FSQ_B_EV_SGL  1
`define FSQ_B_EV_DBL  2
// ======================================================
// encodings and opcodes
`define FSQ_SEC_UNSEC   2'h2
`define FSQ_BACKDOOR_ACCESS_SWITCH_ON    2'h2
`define FSQ_KEY_ZERO    16'h0000
`define FSQ_KEY_ONES    16'hFFFF
`define FSQ_OP_EVALL    8'h01
`define FSQ_OP_KEY      8'h0C
`define FSQ_OP_READ     8'hF0
`define FSQ_KEY_IDX     3'h4
// ======================================================
// reset sequence addresses and defaults
`define FSQ_AD_KEY0     18'h3FF00
`define FSQ_AD_BLKPAR   18'h3FF08
`define FSQ_AD_GUARDS   18'h3FF0C
`define FSQ_AD_OPTSEC   18'h3FF0E
`define FSQ_SEQ_LAST    3'h6
`define FSQ_HOLD_LAST   3'h0
`define FSQ_GUARD_DFLT  8'h00
`define FSQ_OPT_DFLT    8'hFF
`define FSQ_LOCK_DFLT   8'h00
`define FSQ_BLK_DFLT    16'h0000
`define FSQ_MG_BOTH     2'h3
`endif

/* File: dv/fsq_flash_model.sv */
// behavioural flash array engine facing the control block
`timescale 1ns/1ns
module fsq_flash_model #(
  parameter logic [7:0] DLY = 8'h0C
) (
  // clock and reset
  input  logic        clk,
  input  logic        rst,
  // engine port
  input  logic        nvm_req,
  input  logic [17:0] nvm_addr,
  input  logic        df_inj,
  output logic        nvm_done,
  output logic [15:0] nvm_rdata,
  output logic        nvm_err,
  output logic        nvm_dfault
);
  // ======================================================
  // configuration field contents
  logic [7:0]  sec = 8'h81;
  logic [7:0]  cnt;
  logic [15:0] word;
  initial {nvm_done, nvm_rdata, nvm_err, nvm_dfault} = 19'h00000;
  always_comb begin
    case (nvm_addr[3:1])
      3'h0: word = 16'h1234;
      3'h1: word = 16'h5678;
      3'h2: word = 16'h9ABC;
      3'h3: word = 16'hDEF0;
      3'h4: word = 16'h0A5C;
      3'h6: word = 16'h3CC3;
      3'h7: word = {8'h7E, sec};
      default: word = 16'h0000;
    endcase
  end
  // ======================================================
  // answer engine
  // outside a done pulse the data toggles so stale values never look valid
  always @(posedge clk) begin
    nvm_done <= 1'b0;
    nvm_rdata <= ~nvm_rdata;
    nvm_err <= ~nvm_err;
    nvm_dfault <= ~nvm_dfault;
    cnt <= (rst || !nvm_req || nvm_done) ? 8'h00 : cnt + 8'h01;
    if (!rst && nvm_req && !nvm_done && cnt == DLY) begin
      nvm_done <= 1'b1;
      nvm_rdata <= word;
      nvm_err <= 1'b0;
      nvm_dfault <= df_inj;
    end
  end
endmodule // fsq_flash_model

/* File: dv/fsq_flash_ctrl_sva.sv */
// port assertions for the flash control block
`timescale 1ns/1ns
module fsq_flash_ctrl_sva (
  // clock and reset
  input logic        clk,
  input logic        rst,
  // bus and engine
  input logic        psel,
  input logic        pready,
  input logic        nvm_req,
  input logic [7:0]  nvm_op,
  input logic [17:0] nvm_addr,
  input logic        nvm_abort,
  input logic        nvm_done,
  input logic        nvm_err,
  input logic        nvm_dfault,
  // faults, mode, outputs
  input logic        rd_ecc_single,
  input logic        rd_ecc_double,
  input logic        read_block,
  input logic        stop_req,
  input logic        stop_ack,
  input logic [7:0]  lock_register,
  input logic        debug_enable,
  input logic        cmd_irq,
  input logic        err_irq,
  input logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ======================================================
  // helper: bus hold lasts until the first engine answer
  logic hold;
  always_ff @(posedge clk) begin
    if (rst) hold <= 1'b1;
    else if (nvm_done) hold <= 1'b0;
  end
  // ======================================================
  // properties
  property p_hold; hold |-> !pready; endproperty
  a_hold: assert property (p_hold) else $error("bus answered during hold");
  property p_first;
    $fell(rst) |-> ##[1:2] (nvm_req && nvm_op == 8'hF0 && nvm_addr == 18'h3FF08);
  endproperty
  a_first: assert property (p_first) else $error("no block read after reset");
  property p_rstval;
    disable iff (1'b0) rst |=> !nvm_req && !irq && !cmd_irq && !err_irq && !debug_enable
      && lock_register == 8'h00;
  endproperty
  a_rstval: assert property (p_rstval) else $error("bad value in reset");
  property p_abort; disable iff (1'b0) rst && nvm_req |-> ##[1:2] nvm_abort; endproperty
  a_abort: assert property (p_abort) else $error("command not aborted");
  property p_stop; (nvm_req || read_block) |=> !stop_ack; endproperty
  a_stop: assert property (p_stop) else $error("stop granted while busy");
  property p_ack; stop_ack |-> $past(stop_req); endproperty
  a_ack: assert property (p_ack) else $error("stop ack without request");
  property p_blk; $rose(read_block) |-> read_block [*4] ##1 !read_block; endproperty
  a_blk: assert property (p_blk) else $error("read block length wrong");
  property p_cmd; (nvm_req || read_block) |=> !cmd_irq; endproperty
  a_cmd: assert property (p_cmd) else $error("cmd irq while busy");
  property p_err; $rose(err_irq) |-> $past(rd_ecc_single || rd_ecc_double || psel, 2); endproperty
  a_err: assert property (p_err) else $error("err irq without cause");
  property p_irq; $fell(irq) |-> $past(psel, 2); endproperty
  a_irq: assert property (p_irq) else $error("irq fell without write");
  property p_dbg;
    $rose(debug_enable) |-> $past(nvm_done && nvm_op == 8'h01 && !nvm_err && !nvm_dfault);
  endproperty
  a_dbg: assert property (p_dbg) else $error("debug enabled without verify");
endmodule // fsq_flash_ctrl_sva
bind fsq_flash_ctrl fsq_flash_ctrl_sva u_sva (.clk, .rst, .psel, .pready, .nvm_req, .nvm_op,
  .nvm_addr, .nvm_abort, .nvm_done, .nvm_err, .nvm_dfault, .rd_ecc_single, .rd_ecc_double,
  .read_block, .stop_req, .stop_ack, .lock_register, .debug_enable, .cmd_irq, .err_irq, .irq);

/* File: dv/tb.sv */
// self-checking bench for the flash control block
`timescale 1ns/1ns
module tb;
  // ======================================================
  // signals
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic        rd_ecc_single = 1'b0;
  logic        rd_ecc_double = 1'b0;
  logic        special_mode_pin = 1'b0;
  logic        stop_req = 1'b0;
  logic        df_inj = 1'b0;
  wire  [31:0] prdata;
  wire  [17:0] nvm_addr;
  wire  [15:0] nvm_rdata;
  wire  [7:0]  lock_register;
  wire         pready, pslverr, nvm_req, nvm_abort, nvm_done, nvm_err, nvm_dfault;
  wire         read_block, stop_ack, debug_enable, cmd_irq, err_irq, irq;
  int          mismatches = 0;
  int          tests_run = 0;
  logic [31:0] rd;
  logic        er;
  logic        sn;
  logic [15:0] keys [0:4] = '{16'h0, 16'h1234, 16'h5678, 16'h9ABC, 16'h0};
  // rows: address, value after a clean sequence, value after a faulty one
  logic [39:0] rows [0:7] = '{{8'h10, 16'h0000, 16'h0000}, {8'h08, 16'h0080, 16'h0083},
    {8'h1C, 16'h0081, 16'h0000}, {8'h20, 16'h003C, 16'h0000}, {8'h24, 16'h00C3, 16'h0000},
    {8'h28, 16'h007E, 16'h00FF}, {8'h2C, 16'h0A5C, 16'h0000}, {8'h3C, 16'h0000, 16'h0000}};
  always #5 clk = ~clk;
  fsq_flash_ctrl dut (.clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .nvm_req, .nvm_op(), .nvm_addr, .nvm_wdata(), .nvm_wcount(), .nvm_abort,
    .nvm_done, .nvm_rdata, .nvm_err, .nvm_dfault, .rd_ecc_single, .rd_ecc_double,
    .read_block, .special_mode_pin, .stop_req, .stop_ack, .lock_register, .debug_enable,
    .cmd_irq, .err_irq, .irq);
  fsq_flash_model fm (.clk, .rst, .nvm_req, .nvm_addr, .df_inj, .nvm_done, .nvm_rdata,
    .nvm_err, .nvm_dfault);
  // ======================================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chkb(input string nm, input logic got, input logic exp);
    chk(nm, 32'(got), 32'(exp));
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    // hold may stall the answer for a whole sequence read
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wflag;
    // only the watchdog ends a flag that never sets
    do begin
      apb(8'h08, 1'b0, 32'h0);
    end while (rd[7] !== 1'b1);
  endtask
  task automatic cmd(input logic [15:0] w0, input logic [15:0] k3, input int n);
    keys[0] = w0;
    keys[4] = k3;
    for (int i = 0; i <= n; i++) begin
      apb(8'h10, 1'b1, 32'(i));
      apb(8'h14, 1'b1, 32'(keys[i][15:8]));
      apb(8'h18, 1'b1, 32'(keys[i][7:0]));
    end
    apb(8'h08, 1'b1, 32'h80);
  endtask
  task automatic reset_dut;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic rows_chk(input int col);
    for (int i = 0; i < 8; i++) begin
      apb(rows[i][39:32], 1'b0, 32'h0);
      chk($sformatf("reg %h", rows[i][39:32]), rd, 32'(col ? rows[i][15:0] : rows[i][31:16]));
      chkb("slverr", er, rows[i][39:32] == 8'h3C);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ======================================================
  // tests
  initial begin
    #200000;
    mismatches++;
    finish_test;
  end
  initial begin
    reset_dut;
    apb(8'h10, 1'b1, 32'h5);
    apb(8'h08, 1'b0, 32'h0);
    chkb("flag_seq", rd[7], 1'b0);
    wflag;
    rows_chk(0);
    apb(8'h10, 1'b1, 32'h3);
    apb(8'h10, 1'b0, 32'h0);
    chk("idx", rd, 32'h3);
    $display("test reset done");
    apb(8'h38, 1'b1, 32'h7);
    apb(8'h34, 1'b1, 32'h6);
    apb(8'h04, 1'b1, 32'h3);
    for (int k = 0; k < 2; k++) begin
      {rd_ecc_double, rd_ecc_single} <= 2'(1 << k);
      @(posedge clk);
      {rd_ecc_double, rd_ecc_single} <= 2'b00;
      repeat (3) @(negedge clk);
      chkb("err_irq", err_irq, 1'b1);
      chkb("irq", irq, 1'b1);
      apb(8'h0C, 1'b1, 32'(1 << k));
      apb(8'h38, 1'b1, 32'(2 << k));
      repeat (3) @(negedge clk);
      chkb("err_irq_off", err_irq, 1'b0);
      chkb("irq_off", irq, 1'b0);
      @(posedge clk);
    end
    $display("test fault irq done");
    special_mode_pin <= 1'b1;
    stop_req <= 1'b1;
    apb(8'h38, 1'b1, 32'h7);
    apb(8'h34, 1'b1, 32'h1);
    apb(8'h00, 1'b1, 32'h1);
    cmd(16'h0100, 16'h0000, 0);
    repeat (2) @(negedge clk);
    chkb("stop_busy", stop_ack, 1'b0);
    chkb("cmd_irq_busy", cmd_irq, 1'b0);
    wflag;
    @(negedge clk);
    chkb("stop_ack", stop_ack, 1'b1);
    chkb("cmd_irq", cmd_irq, 1'b1);
    chkb("irq_cmd", irq, 1'b1);
    chkb("debug", debug_enable, 1'b1);
    chk("lock_ev", 32'(lock_register), 32'h82);
    apb(8'h38, 1'b1, 32'h1);
    apb(8'h00, 1'b1, 32'h0);
    stop_req <= 1'b0;
    special_mode_pin <= 1'b0;
    repeat (3) @(negedge clk);
    chkb("cmd_irq_off", cmd_irq, 1'b0);
    chkb("irq_cmd_off", irq, 1'b0);
    $display("test erase verify done");
    // erase verify left the part unsecured; reset to reload the secured byte
    @(posedge clk);
    reset_dut;
    wflag;
    chk("lock_reload", 32'(lock_register), 32'h81);
    cmd(16'h0C00, 16'h0000, 4);
    wflag;
    chk("lock_bad", 32'(lock_register), 32'h81);
    cmd(16'h0C00, 16'hDEF0, 4);
    wflag;
    chkb("accerr", rd[5], 1'b1);
    chk("lock_blk", 32'(lock_register), 32'h81);
    fm.sec <= 8'h80;
    cmd(16'h1200, 16'h0000, 1);
    repeat (3) @(negedge clk);
    chk("lock_keep", 32'(lock_register), 32'h81);
    chkb("busy", nvm_req, 1'b1);
    @(posedge clk);
    rst <= 1'b1;
    sn = 1'b0;
    repeat (3) begin
      @(negedge clk);
      sn = sn | nvm_abort;
    end
    chkb("abort", sn, 1'b1);
    @(posedge clk);
    rst <= 1'b0;
    wflag;
    chk("lock_new", 32'(lock_register), 32'h80);
    cmd(16'h0C00, 16'hDEF0, 4);
    wflag;
    chk("lock_unsec", 32'(lock_register), 32'h82);
    apb(8'h20, 1'b0, 32'h0);
    chk("guard_keep", rd, 32'h3C);
    $display("test key verify done");
    df_inj <= 1'b1;
    reset_dut;
    wflag;
    rows_chk(1);
    $display("test faulty sequence done");
    finish_test;
  end
endmodule // tb
